// >>> src/dgccr_top.sv
// DMA global control register and channel 2 address, size and pointer registers on AHB-Lite.
`timescale 1ns/100ps
// ============================================================================
// ============================================================================
module dgccr_top
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Transfer engine status, same clock.
	input  wire logic        engine_moving,
	input  wire logic [15:0] src_ptr_in,
	input  wire logic [15:0] dst_ptr_in,
	// Transfer engine control.
	output logic             dma_enable,
	output logic             transfer_permit,
	output logic [31:0]      dest_start_address,
	output logic [15:0]      source_size_field,
	output logic [15:0]      dest_size_field,
	output logic [15:0]      cell_size_field
);

	// ========================================================================
	// Helpers.
	// ========================================================================
	// Alias arithmetic: only bits written as 1 are touched by clear, set, invert.
	function automatic logic [31:0] apply_alias(input logic [31:0] old, input logic [31:0] wd,
		input logic [1:0] kind);
	begin
		case (kind)
			dgccr_pkg::ALIAS_CLR:   apply_alias = old & ~wd;
			dgccr_pkg::ALIAS_SET:   apply_alias = old | wd;
			dgccr_pkg::ALIAS_INV:   apply_alias = old ^ wd;
			default:                apply_alias = wd;
		endcase
	end
	endfunction

	// ========================================================================
	// Register state.
	// ========================================================================
	logic        on_reg;
	logic        suspend_reg;
	logic [31:0] dsa_reg;
	logic [15:0] ssiz_reg;
	logic [15:0] dsiz_reg;
	logic [15:0] csiz_reg;
	logic [15:0] sptr_reg;
	logic [15:0] dptr_reg;
	logic        wr_pend_reg;
	logic        rd_wait_reg;
	logic        rd_done_reg;
	logic [15:0] base_reg;
	logic [1:0]  kind_reg;
	logic [31:0] hrdata_reg;
	logic        busy;
	logic [31:0] ctrl_word;
	logic        addr_phase;
	logic [31:0] rd_next;
	logic [31:0] ctrl_next;

	// Engine outputs follow the control bits directly.
	assign dma_enable         = on_reg;
	assign transfer_permit    = on_reg & ~suspend_reg;
	assign busy               = on_reg | engine_moving;
	assign ctrl_word          = {16'h0000, on_reg, 2'h0, suspend_reg, busy, 11'h000};
	assign dest_start_address = dsa_reg;
	assign source_size_field  = ssiz_reg;
	assign dest_size_field    = dsiz_reg;
	assign cell_size_field    = csiz_reg;

	// ========================================================================
	// AHB-Lite protocol.
	// ========================================================================
	// Reads take one wait state so that a write just before always shows up.
	assign addr_phase = hsel & hready & (htrans == dgccr_pkg::HTRANS_NSEQ);
	assign hreadyout  = ~rd_wait_reg;
	assign hresp      = dgccr_pkg::HRESP_OKAY;
	assign hrdata     = hrdata_reg;

	// Address phase capture; hsize is not checked since only words are issued.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			rd_done_reg <= 1'b0;
			base_reg    <= 16'h0000;
			kind_reg    <= 2'h0;
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite;
			rd_wait_reg <= addr_phase & ~hwrite;
			rd_done_reg <= rd_wait_reg;
			if (addr_phase)
			begin
				base_reg <= {haddr[15:4], 4'h0};
				kind_reg <= haddr[3:2];
			end
		end
	end

	// Read multiplexer; an alias address reads the same word as its base.
	always_comb
	begin
		case (base_reg)
			dgccr_pkg::CTRL_OFS: rd_next = ctrl_word & dgccr_pkg::CTRL_RMASK;
			dgccr_pkg::DSA_OFS:  rd_next = dsa_reg;
			dgccr_pkg::SSIZ_OFS: rd_next = {16'h0000, ssiz_reg};
			dgccr_pkg::DSIZ_OFS: rd_next = {16'h0000, dsiz_reg};
			dgccr_pkg::SPTR_OFS: rd_next = {16'h0000, sptr_reg};
			dgccr_pkg::DPTR_OFS: rd_next = {16'h0000, dptr_reg};
			dgccr_pkg::CSIZ_OFS: rd_next = {16'h0000, csiz_reg};
			default:             rd_next = dgccr_pkg::RESET_WORD;
		endcase
	end

	// Read data register, loaded in the wait state of a read.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= dgccr_pkg::RESET_WORD;
		else if (rd_wait_reg)
			hrdata_reg <= rd_next;
	end

	// ========================================================================
	// Writable registers.
	// ========================================================================
	// Alias result on the control word; only the enable and suspend bits of it are kept.
	assign ctrl_next = apply_alias(ctrl_word, hwdata, kind_reg);

	// Global control: only enable and suspend hold state; other bits drop writes.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			on_reg      <= 1'b0;
			suspend_reg <= 1'b0;
		end
		else if (wr_pend_reg && base_reg == dgccr_pkg::CTRL_OFS)
		begin
			on_reg      <= ctrl_next[dgccr_pkg::ON_BIT];
			suspend_reg <= ctrl_next[dgccr_pkg::SUSPEND_BIT];
		end
	end

	// Channel address and size registers; size fields keep their low half only.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dsa_reg  <= dgccr_pkg::RESET_WORD;
			ssiz_reg <= 16'h0000;
			dsiz_reg <= 16'h0000;
			csiz_reg <= 16'h0000;
		end
		else if (wr_pend_reg)
		begin
			case (base_reg)
				dgccr_pkg::DSA_OFS:  dsa_reg  <= apply_alias(dsa_reg, hwdata, kind_reg);
				dgccr_pkg::SSIZ_OFS: ssiz_reg <= 16'(apply_alias({16'h0000, ssiz_reg}, hwdata, kind_reg));
				dgccr_pkg::DSIZ_OFS: dsiz_reg <= 16'(apply_alias({16'h0000, dsiz_reg}, hwdata, kind_reg));
				dgccr_pkg::CSIZ_OFS: csiz_reg <= 16'(apply_alias({16'h0000, csiz_reg}, hwdata, kind_reg));
				default:             dsa_reg  <= dsa_reg;
			endcase
		end
	end

	// Pointers mirror the engine; software writes to them and their aliases are dropped.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sptr_reg <= 16'h0000;
			dptr_reg <= 16'h0000;
		end
		else
		begin
			sptr_reg <= src_ptr_in;
			dptr_reg <= dst_ptr_in;
		end
	end

	// ========================================================================
	// Assertions.
	// ========================================================================
	// Write data of the previous edge, kept for the alias checks below.
	logic [31:0] past_wdata;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			past_wdata <= dgccr_pkg::RESET_WORD;
		else
			past_wdata <= hwdata;
	end

	sequence s_ctrl_write;
		wr_pend_reg && base_reg == dgccr_pkg::CTRL_OFS && kind_reg == dgccr_pkg::ALIAS_PLAIN;
	endsequence

	sequence s_dsa_alias(logic [1:0] k);
		wr_pend_reg && base_reg == dgccr_pkg::DSA_OFS && kind_reg == k;
	endsequence

	sequence s_ctrl_alias(logic [1:0] k);
		wr_pend_reg && base_reg == dgccr_pkg::CTRL_OFS && kind_reg == k;
	endsequence

	sequence s_ctrl_read;
		rd_wait_reg && base_reg == dgccr_pkg::CTRL_OFS ##1 rd_done_reg;
	endsequence

	a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
		s_ctrl_write |=> dma_enable == past_wdata[15]) else $error("enable bit not taken");

	a_suspend_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_ctrl_write ##1 (dma_enable && past_wdata[12])) |-> !transfer_permit)
		else $error("transfer allowed while suspended");

	a_busy_view: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_wait_reg && base_reg == dgccr_pkg::CTRL_OFS) |=> hrdata[11] == $past(on_reg | engine_moving))
		else $error("busy flag misread");

	a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		s_ctrl_read |-> (hrdata & ~dgccr_pkg::CTRL_RMASK) == 32'h0000_0000)
		else $error("reserved control bits not zero");

	a_set_alias: assert property (@(posedge hclk) disable iff (!hresetn)
		s_dsa_alias(dgccr_pkg::ALIAS_SET) |=> dsa_reg == ($past(dsa_reg) | past_wdata))
		else $error("set alias wrong");

	a_clr_alias: assert property (@(posedge hclk) disable iff (!hresetn)
		s_dsa_alias(dgccr_pkg::ALIAS_CLR) |=> dsa_reg == ($past(dsa_reg) & ~past_wdata))
		else $error("clear alias wrong");

	a_inv_alias: assert property (@(posedge hclk) disable iff (!hresetn)
		s_dsa_alias(dgccr_pkg::ALIAS_INV) |=> dsa_reg == ($past(dsa_reg) ^ past_wdata))
		else $error("invert alias wrong");

	// Checked from the second edge in reset, since the first edge may still sample power-up unknowns.
	a_reset_zero: assert property (@(posedge hclk)
		(!hresetn ##1 !hresetn) |-> dest_start_address == 32'h0000_0000 && source_size_field == 16'h0000
		&& dest_size_field == 16'h0000 && cell_size_field == 16'h0000 && !dma_enable)
		else $error("registers not zero in reset");

	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_phase && !hwrite) |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");

	// Alias writes on the control word reach the engine outputs on the next cycle.
	a_suspend_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_ctrl_alias(dgccr_pkg::ALIAS_SET) ##0 hwdata[dgccr_pkg::SUSPEND_BIT]) |=> !transfer_permit)
		else $error("set suspend did not stop transfers");

	a_disable_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_ctrl_alias(dgccr_pkg::ALIAS_CLR) ##0 hwdata[dgccr_pkg::ON_BIT]) |=> !dma_enable && !transfer_permit)
		else $error("clear enable did not switch off");

	// Busy view in both directions: moving engine shows busy, idle and off shows not busy.
	a_moving_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_wait_reg && base_reg == dgccr_pkg::CTRL_OFS && engine_moving) |=> hrdata[dgccr_pkg::BUSY_BIT])
		else $error("busy flag low while moving");

	a_idle_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_wait_reg && base_reg == dgccr_pkg::CTRL_OFS && !on_reg && !engine_moving)
		|=> !hrdata[dgccr_pkg::BUSY_BIT]) else $error("busy flag high while idle");

	// Size registers keep only their low half; the upper half reads zero.
	a_size_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_wait_reg && base_reg == dgccr_pkg::SSIZ_OFS) |=> hrdata[31:16] == 16'h0000)
		else $error("size upper half not zero");

	a_cell_plain: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_reg && base_reg == dgccr_pkg::CSIZ_OFS && kind_reg == dgccr_pkg::ALIAS_PLAIN)
		|=> cell_size_field == past_wdata[15:0]) else $error("cell size write lost");

	// Pointer writes are dropped: the pointers keep following the engine.
	a_src_ptr_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_reg && base_reg == dgccr_pkg::SPTR_OFS) |=> sptr_reg == $past(src_ptr_in))
		else $error("source pointer took a write");

	a_dst_ptr_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_reg && base_reg == dgccr_pkg::DPTR_OFS) |=> dptr_reg == $past(dst_ptr_in))
		else $error("dest pointer took a write");

	// Writes never stall, and read data only moves in the wait state of a read.
	a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_reg |-> hreadyout) else $error("write data phase stalled");

	a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!rd_wait_reg |=> $stable(hrdata)) else $error("read data moved outside a read");

endmodule // dgccr_top

// >>> src/dgccr_pkg.sv
// Constants for the DMA global control and channel 2 register block.
package dgccr_pkg;

	// ========================================================================
	// Register map, byte offsets within the 64 KiB window.
	// ========================================================================
	localparam logic [15:0] CTRL_OFS     = 16'h3000;
	localparam logic [15:0] DSA_OFS      = 16'h3220;
	localparam logic [15:0] SSIZ_OFS     = 16'h3230;
	localparam logic [15:0] DSIZ_OFS     = 16'h3240;
	localparam logic [15:0] SPTR_OFS     = 16'h3250;
	localparam logic [15:0] DPTR_OFS     = 16'h3260;
	localparam logic [15:0] CSIZ_OFS     = 16'h3270;

	// ========================================================================
	// Alias selector, the word offset above each register base.
	// ========================================================================
	localparam logic [1:0]  ALIAS_PLAIN  = 2'h0;
	localparam logic [1:0]  ALIAS_CLR    = 2'h1;
	localparam logic [1:0]  ALIAS_SET    = 2'h2;
	localparam logic [1:0]  ALIAS_INV    = 2'h3;

	// ========================================================================
	// Field positions and reset values.
	// ========================================================================
	localparam int          ON_BIT       = 15;
	localparam int          SUSPEND_BIT  = 12;
	localparam int          BUSY_BIT     = 11;
	localparam int          FIELD_W      = 16;
	localparam logic [31:0] CTRL_WMASK   = 32'h0000_9000;
	localparam logic [31:0] CTRL_RMASK   = 32'h0000_9800;
	localparam logic [31:0] FIELD_MASK   = 32'h0000_ffff;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

	// ========================================================================
	// AHB-Lite encodings.
	// ========================================================================
	localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
	localparam logic        HRESP_OKAY   = 1'h0;

endpackage

// >>> verification/dgccr_engine_model.sv
// Behavioural model of the transfer engine that sits behind the control block.
`timescale 1ns/100ps
module dgccr_engine_model
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Control from the block and the bench.
	input  wire logic        transfer_permit,
	input  wire logic        run,
	// Status back to the block.
	output logic             engine_moving,
	output logic [15:0]      src_ptr_in,
	output logic [15:0]      dst_ptr_in
);
	// ========================================================================
	// Engine activity
	// ========================================================================
	// The engine moves only while permitted, so a suspend or a disable stops it within one cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			engine_moving <= 1'b0;
			src_ptr_in    <= 16'h0000;
			dst_ptr_in    <= 16'h0000;
		end
		else
		begin
			engine_moving <= run & transfer_permit;
			if (engine_moving)
			begin
				src_ptr_in <= src_ptr_in + 16'h0001;
				dst_ptr_in <= dst_ptr_in + 16'h0002;
			end
		end
	end
endmodule // dgccr_engine_model

// >>> verification/tb_top.sv
// Self-checking testbench for the DMA global control and channel 2 register block.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
	// ========================================================================
	// Signals
	// ========================================================================
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic        hreadyout, hresp, dma_enable, transfer_permit, engine_moving;
	logic [31:0] hrdata, dest_start_address;
	logic [15:0] src_ptr_in, dst_ptr_in, source_size_field, dest_size_field, cell_size_field;
	logic [15:0] ofs [4];
	logic [31:0] e, m;
	int          bad_count = 0, cmp_count = 0;

	always #10 hclk = ~hclk;

	dgccr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .engine_moving(engine_moving), .src_ptr_in(src_ptr_in),
		.dst_ptr_in(dst_ptr_in), .dma_enable(dma_enable), .transfer_permit(transfer_permit),
		.dest_start_address(dest_start_address), .source_size_field(source_size_field),
		.dest_size_field(dest_size_field), .cell_size_field(cell_size_field));
	dgccr_engine_model engine (.hclk(hclk), .hresetn(hresetn), .transfer_permit(transfer_permit),
		.run(run), .engine_moving(engine_moving), .src_ptr_in(src_ptr_in), .dst_ptr_in(dst_ptr_in));

	// ========================================================================
	// Shared tasks
	// ========================================================================
	task automatic wrap_up;
		$display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One single AHB-Lite transfer; the master waits on hready in both phases, never a fixed count.
	// Ready and read data are taken at the rising edge itself, before that edge's updates land.
	task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
		int   n;
		logic rdy;
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= dgccr_pkg::HTRANS_NSEQ;
		hwrite <= w;
		haddr  <= {16'h0000, a};
		n = 0;
		do
		begin
			@(posedge hclk);
			rdy = hreadyout;
			n++;
		end
		while (rdy !== 1'b1 && n < 50);
		if (rdy === 1'b1)
		begin
			htrans <= 2'h0;
			hsel   <= 1'b0;
			hwdata <= d;
			do
			begin
				@(posedge hclk);
				rdy = hreadyout;
				n++;
			end
			while (rdy !== 1'b1 && n < 100);
		end
		r = hrdata;
		if (rdy !== 1'b1)
		begin
			bad_count++;
			$display("ERROR %0t bus transfer hung", $time);
			wrap_up();
		end
		`CHK(hresp, dgccr_pkg::HRESP_OKAY)
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		`CHK(r, x)
	endtask

	// ========================================================================
	// Scenarios
	// ========================================================================
	task automatic t_reset;
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::DSA_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::SSIZ_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::DSIZ_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::SPTR_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::DPTR_OFS, 32'h0000_0000);
		rdchk(dgccr_pkg::CSIZ_OFS, 32'h0000_0000);
		`CHK(dma_enable, 1'b0)
	endtask

	// Reset in mid-run while the channel registers hold data; everything must come back as zero.
	task automatic t_midreset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK(dest_start_address, 32'h0000_0000)
		`CHK(cell_size_field, 16'h0000)
		hresetn <= 1'b1;
		t_reset();
	endtask

	task automatic t_ctrl;
		wr(dgccr_pkg::CTRL_OFS, 32'hffff_ffff);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_9800);
		`CHK(transfer_permit, 1'b0)
		`CHK(dma_enable, 1'b1)
		wr(dgccr_pkg::CTRL_OFS + 16'h0004, 32'h0000_1000);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_8800);
		`CHK(transfer_permit, 1'b1)
		wr(dgccr_pkg::CTRL_OFS + 16'h0004, 32'h0000_8000);
		@(posedge hclk);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_0000);
	endtask

	// Plain write, then set, invert and clear aliases; only bits written as one may move.
	task automatic t_alias;
		ofs = '{dgccr_pkg::DSA_OFS, dgccr_pkg::SSIZ_OFS, dgccr_pkg::DSIZ_OFS, dgccr_pkg::CSIZ_OFS};
		foreach (ofs[i])
		begin
			m = (i == 0) ? 32'hffff_ffff : dgccr_pkg::FIELD_MASK;
			e = 32'h1234_5678 & m;
			wr(ofs[i], 32'h1234_5678);
			rdchk(ofs[i], e);
			wr(ofs[i] + 16'h0008, 32'h0000_0003);
			rdchk(ofs[i], e | 32'h0000_0003);
			wr(ofs[i] + 16'h000c, 32'h00ff_00ff);
			rdchk(ofs[i], (e | 32'h0000_0003) ^ (32'h00ff_00ff & m));
			wr(ofs[i] + 16'h0004, 32'h0f00_0f00);
			rdchk(ofs[i], ((e | 32'h0000_0003) ^ (32'h00ff_00ff & m)) & ~32'h0f00_0f00);
		end
		`CHK(dest_start_address, 32'h10cb_5084)
		`CHK(source_size_field, 16'h5084)
		`CHK(dest_size_field, 16'h5084)
		`CHK(cell_size_field, 16'h5084)
	endtask

	task automatic t_engine;
		wr(dgccr_pkg::CTRL_OFS, 32'h0000_8000);
		run <= 1'b1;
		repeat (5) @(posedge hclk);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_8800);
		wr(dgccr_pkg::CTRL_OFS + 16'h0008, 32'h0000_1000);
		repeat (3) @(posedge hclk);
		#1;
		`CHK({transfer_permit, engine_moving}, 2'b00)
		wr(dgccr_pkg::SPTR_OFS, 32'hffff_ffff);
		rdchk(dgccr_pkg::SPTR_OFS, {16'h0000, src_ptr_in});
		wr(dgccr_pkg::DPTR_OFS, 32'hffff_ffff);
		rdchk(dgccr_pkg::DPTR_OFS, {16'h0000, dst_ptr_in});
		wr(dgccr_pkg::CTRL_OFS + 16'h0004, 32'h0000_8000);
		@(posedge hclk);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_1000);
		wr(dgccr_pkg::CTRL_OFS + 16'h000c, 32'h0000_1000);
		rdchk(dgccr_pkg::CTRL_OFS, 32'h0000_0000);
		run <= 1'b0;
	endtask

	// ========================================================================
	// Main sequence and watchdog
	// ========================================================================
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_alias();
		t_midreset();
		t_engine();
		wrap_up();
	end

	initial
	begin
		#1000000;
		bad_count++;
		$display("ERROR %0t run did not finish", $time);
		wrap_up();
	end
endmodule // tb_top
